// *** rtl/tsd_pkg.sv ***
package tsd_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned TERM_N = 4;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_BANDGAP = 10'h07C;
  localparam logic [9:0] IDX_TERM_FIRST = 10'h07E;
  localparam logic [9:0] IDX_TERM_SECOND = 10'h07F;
  localparam logic [9:0] IDX_TERM_THIRD = 10'h080;
  localparam logic [9:0] IDX_TERM_FOURTH = 10'h081;
  localparam logic [9:0] IDX_SWAP_DELAY = 10'h09A;
  // field layout
  localparam int unsigned BANDGAP_LSB = 0;
  localparam int unsigned BANDGAP_W = 4;
  localparam int unsigned TERM_TRIM_LSB = 0;
  localparam int unsigned TERM_TRIM_W = 8;
  localparam int unsigned SWAP_DLY_LSB = 0;
  localparam int unsigned SWAP_DLY_W = 5;
  // reset values (trims come from the fuse store instead)
  localparam logic [7:0] SWAP_DLY_RESET = 8'h08;
  localparam logic [7:0] RSVD_RESET = 8'h00;
  // overlap = base + 2 * delay core clock cycles
  localparam int unsigned OVL_CNT_W = 7;
  localparam logic [6:0] OVL_BASE_CYCLES = 7'h04;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/tsd_overlap_timer.sv ***
`timescale 1ns/1ns
module tsd_overlap_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       swap_start,
  input  wire logic [4:0] overlap_count,
  output logic            overlap_active
);
  logic [tsd_pkg::OVL_CNT_W-1:0] remain_q;
  logic [tsd_pkg::OVL_CNT_W-1:0] remain_d;
  logic [tsd_pkg::OVL_CNT_W-1:0] total;
  logic                          active_q;
  logic                          active_d;
  wire                           start_ok = swap_start && !active_q;

  // both cores sample together for base plus twice the delay
  assign total = tsd_pkg::OVL_BASE_CYCLES
               + {1'b0, overlap_count, 1'b0};
  assign remain_d = start_ok ? total - 7'h01
                  : (active_q && remain_q != 7'h00) ? remain_q - 7'h01
                  : remain_q;
  assign active_d = start_ok ? 1'b1
                  : (active_q && remain_q == 7'h00) ? 1'b0
                  : active_q;
  assign overlap_active = active_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain_q <= 7'h00;
      active_q <= 1'b0;
    end else begin
      remain_q <= remain_d;
      active_q <= active_d;
    end
  end

  // helper: length of the current overlap and base plus twice delay latched at start
  logic [7:0] len_q;
  logic [6:0] want_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q  <= 8'h00;
      want_q <= 7'h00;
    end else begin
      len_q  <= start_ok ? 8'h01 : (active_q ? len_q + 8'h01 : 8'h00);
      want_q <= start_ok ? total : want_q;
    end
  end

  a_overlap_length: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $fell(active_q) |-> $past(len_q) == {1'b0, want_q})
    else $error("overlap length differs from base plus twice delay");
  a_overlap_start: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (swap_start && !active_q) |=> active_q [*4])
    else $error("overlap shorter than base cycles");
endmodule

// *** rtl/tsd_regs.sv ***
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// - the band-gap trim is a 4-bit field in bits 3:0, bits 7:4 reserved.
// - at reset every trim register takes its value from the fuse store.
// - software reads the fused trim after reset and a write replaces it.
// - four 8-bit termination trims, one per analog input, in bits 7:0.
// - a core swap overlaps both cores for 4 plus twice the delay cycles.
// - the overlap delay sits in bits 4:0, spans 0 to 31, resets to 0x08.
module tsd_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  fuse_bandgap,
  input  wire logic [31:0] fuse_termination,
  input  wire logic        swap_start,
  output logic [3:0]       bandgap_trim_code,
  output logic [7:0]       termination_trim_first,
  output logic [7:0]       termination_trim_second,
  output logic [7:0]       termination_trim_third,
  output logic [7:0]       termination_trim_fourth,
  output logic [4:0]       swap_overlap_count,
  output logic             core_overlap_active
);
  // write channel holding state
  logic        awready_q;
  logic        wready_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [9:0]  aw_idx_q;
  logic [7:0]  wdata_q;
  logic        wlane0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  // read channel
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  // register storage
  logic [7:0]  bg_q;
  logic [7:0]  term_q [tsd_pkg::TERM_N];
  logic [7:0]  dly_q;

  wire aw_hs = s_axi_awvalid && awready_q;
  wire w_hs = s_axi_wvalid && wready_q;
  wire ar_hs = s_axi_arvalid && arready_q;
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire wr_en = wr_go && wlane0_q;

  // write decode
  wire sel_w_bg = aw_idx_q == tsd_pkg::IDX_BANDGAP;
  wire sel_w_dly = aw_idx_q == tsd_pkg::IDX_SWAP_DELAY;
  wire [3:0] sel_w_term;
  assign sel_w_term[0] = aw_idx_q == tsd_pkg::IDX_TERM_FIRST;
  assign sel_w_term[1] = aw_idx_q == tsd_pkg::IDX_TERM_SECOND;
  assign sel_w_term[2] = aw_idx_q == tsd_pkg::IDX_TERM_THIRD;
  assign sel_w_term[3] = aw_idx_q == tsd_pkg::IDX_TERM_FOURTH;
  wire w_mapped = sel_w_bg || sel_w_dly || (|sel_w_term);

  // read decode, straight from the address bus
  wire [9:0] ar_idx = s_axi_araddr[11:2];
  logic [7:0] rd_byte;
  logic       rd_mapped;
  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    if (ar_idx == tsd_pkg::IDX_BANDGAP) begin
      rd_byte = bg_q;
    end else if (ar_idx == tsd_pkg::IDX_TERM_FIRST) begin
      rd_byte = term_q[0];
    end else if (ar_idx == tsd_pkg::IDX_TERM_SECOND) begin
      rd_byte = term_q[1];
    end else if (ar_idx == tsd_pkg::IDX_TERM_THIRD) begin
      rd_byte = term_q[2];
    end else if (ar_idx == tsd_pkg::IDX_TERM_FOURTH) begin
      rd_byte = term_q[3];
    end else if (ar_idx == tsd_pkg::IDX_SWAP_DELAY) begin
      rd_byte = dly_q;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 8'h00;
      wlane0_q  <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata[7:0];
        wlane0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tsd_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= w_mapped ? tsd_pkg::RESP_OKAY : tsd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= tsd_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_mapped ? tsd_pkg::RESP_OKAY : tsd_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // fuse values land on the synchronous reset; fuse store shares aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_q <= {tsd_pkg::RSVD_RESET[7:4], fuse_bandgap};
    end else if (wr_en && sel_w_bg) begin
      bg_q <= wdata_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < tsd_pkg::TERM_N; gi++) begin : g_term
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          term_q[gi] <= fuse_termination[gi*8 +: 8];
        end else if (wr_en && sel_w_term[gi]) begin
          term_q[gi] <= wdata_q;
        end
      end
    end
  endgenerate

  // reserved bits are stored as written; software keeps them zero
  // no interlock against calibration; software owns that ordering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_q <= tsd_pkg::SWAP_DLY_RESET;
    end else if (wr_en && sel_w_dly) begin
      dly_q <= wdata_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // trims drive the analog controls with no further command
  assign bandgap_trim_code =
    bg_q[tsd_pkg::BANDGAP_LSB +: tsd_pkg::BANDGAP_W];
  assign termination_trim_first = term_q[0];
  assign termination_trim_second = term_q[1];
  assign termination_trim_third = term_q[2];
  assign termination_trim_fourth = term_q[3];
  assign swap_overlap_count =
    dly_q[tsd_pkg::SWAP_DLY_LSB +: tsd_pkg::SWAP_DLY_W];

  tsd_overlap_timer u_overlap (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .swap_start     (swap_start),
    .overlap_count  (swap_overlap_count),
    .overlap_active (core_overlap_active)
  );

  a_bg_fuse_load: assert property (@(posedge aclk)
    $rose(aresetn) |-> bandgap_trim_code == $past(fuse_bandgap))
    else $error("band-gap trim not loaded from fuse at reset");
  a_term_fuse_load: assert property (@(posedge aclk)
    $rose(aresetn)
    |-> termination_trim_third == $past(fuse_termination[23:16]))
    else $error("termination trim not loaded from fuse at reset");
  a_dly_reset_val: assert property (@(posedge aclk)
    $rose(aresetn) |-> swap_overlap_count == 5'h08)
    else $error("overlap delay reset value wrong");
  a_bg_field_width: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (wr_en && sel_w_bg) |=> bandgap_trim_code == $past(wdata_q[3:0]))
    else $error("band-gap trim write not in bits 3:0");
  a_term_write_out: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (w_hs && aw_hs && s_axi_wstrb[0] && !bvalid_q
     && s_axi_awaddr[11:2] == 10'h07F)
    |=> ##1 termination_trim_second == $past(s_axi_wdata[7:0], 2))
    else $error("second termination trim write lost");
  a_read_back_bg: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (ar_hs && ar_idx == 10'h07C) |=> s_axi_rvalid
    && s_axi_rdata == {24'h00_0000, $past(bg_q)})
    else $error("band-gap read does not return stored trim");
  a_dly_write_out: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (wr_en && sel_w_dly) |=> swap_overlap_count == $past(wdata_q[4:0]))
    else $error("overlap delay write not in bits 4:0");
  a_trim_steady: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !(wr_en && sel_w_term[0]) |=> $stable(termination_trim_first))
    else $error("first termination trim changed without a write");
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  fuse_bg;
  logic [31:0] fuse_term;
  logic        swap_start;
  logic [3:0]  bg_code;
  logic [7:0]  term [4];
  logic [4:0]  ovl_count;
  logic        ovl_active;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [11:0] taddr [4];
  logic [7:0]  tval [4];
  int          errors;
  int          comparisons;

  always #10 aclk = ~aclk;

  tsd_regs u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fuse_bandgap(fuse_bg),
    .fuse_termination(fuse_term), .swap_start(swap_start),
    .bandgap_trim_code(bg_code), .termination_trim_first(term[0]),
    .termination_trim_second(term[1]), .termination_trim_third(term[2]),
    .termination_trim_fourth(term[3]), .swap_overlap_count(ovl_count),
    .core_overlap_active(ovl_active));

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // aw and w offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    r = bresp;
    if (n >= 50) begin
      errors++;
      summarize();
    end
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 50) begin
      errors++;
      summarize();
    end
  endtask

  task automatic defaults();
    axr(ba(tsd_pkg::IDX_BANDGAP), rd, rsp);
    chk(rd, {28'h0, fuse_bg});
    chk(bg_code, fuse_bg);
    for (int i = 0; i < 4; i++) begin
      axr(taddr[i], rd, rsp);
      chk(rd, {24'h0, fuse_term[8*i +: 8]});
      chk(term[i], fuse_term[8*i +: 8]);
    end
    axr(ba(tsd_pkg::IDX_SWAP_DELAY), rd, rsp);
    chk(rd, 32'h08);
    chk(ovl_count, 5'h08);
  endtask

  // second start falls inside the overlap and must be ignored
  task automatic ovl(input logic [4:0] c);
    int n;
    n = 0;
    axw(ba(tsd_pkg::IDX_SWAP_DELAY), {27'h0, c}, rsp);
    chk(ovl_count, c);
    for (int i = 0; i < 84; i++) begin
      @(posedge aclk);
      if (i > 1) n += ovl_active;
      swap_start <= (i == 0 || i == 2);
    end
    chk(n, 4 + 2 * c);
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize();
  end

  initial begin
    aclk = 1'b0;
    {errors, comparisons} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, swap_start} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    fuse_bg = 4'h5;
    fuse_term = 32'hD4C3B2A1;
    taddr = '{ba(tsd_pkg::IDX_TERM_FIRST), ba(tsd_pkg::IDX_TERM_SECOND),
              ba(tsd_pkg::IDX_TERM_THIRD), ba(tsd_pkg::IDX_TERM_FOURTH)};
    tval = '{8'hFF, 8'h00, 8'h5A, 8'hA5};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    defaults();
    $display("test fuse defaults done");
    axw(ba(tsd_pkg::IDX_BANDGAP), 32'h0000000A, rsp);
    chk(rsp, tsd_pkg::RESP_OKAY);
    axr(ba(tsd_pkg::IDX_BANDGAP), rd, rsp);
    chk(rd, 32'h0000000A);
    chk(rsp, tsd_pkg::RESP_OKAY);
    chk(bg_code, 4'hA);
    for (int i = 0; i < 4; i++) begin
      axw(taddr[i], {24'h0, tval[i]}, rsp);
      axr(taddr[i], rd, rsp);
      chk(rd, {24'h0, tval[i]});
      chk(term[i], tval[i]);
    end
    wstrb <= 4'h0;
    axw(taddr[0], 32'h00000011, rsp);
    chk(rsp, tsd_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axr(taddr[0], rd, rsp);
    chk(rd, 32'h000000FF);
    $display("test trim writes done");
    axw(12'h1F4, 32'h0000003C, rsp);
    chk(rsp, tsd_pkg::RESP_SLVERR);
    axr(12'h1F4, rd, rsp);
    chk(rd, 32'h0);
    chk(rsp, tsd_pkg::RESP_SLVERR);
    $display("test unmapped done");
    ovl(5'h00);
    ovl(5'h1F);
    ovl(5'h07);
    ovl(5'h08);
    $display("test overlap done");
    fuse_bg <= 4'h9;
    fuse_term <= 32'h1E2D3C4B;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    defaults();
    $display("test second reset done");
    summarize();
  end
endmodule
